// ==== hdl/esled_interval.v ====
// esled_interval.v: retriggerable millisecond interval timer
// assumes tick is a one-cycle pulse once per ms, start is one cycle
`timescale 1ns/100ps

module esled_interval #(
   parameter W = 10
) (
   input wire clk,
   input wire rst_n,
   input wire tick,
   input wire start,
   input wire [W-1:0] length,
   output reg busy
);

   reg [W-1:0] cnt_reg;

   // start reloads the full length, so a fresh event restarts the interval
   // an extra tick is counted since the first tick may come at once
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= {W{1'b0}};
         busy <= 1'b0;
      end else if (start) begin
         cnt_reg <= length;
         busy <= 1'b1;
      end else if (tick && busy) begin
         if (cnt_reg == {W{1'b0}}) begin
            busy <= 1'b0;
         end else begin
            cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // esled_interval

// ==== hdl/esled_top.v ====
// esled_top.v: status led driver of an ethernet controller
// assumes event inputs are one-cycle pulses or levels synchronous to clk
//
// Behaviour
// (R1) transmit led active low, lit by default
// (R2) transmitted packet turns transmit led off 90ms
// (R3) transmit led stays lit 18ms between blinks
// (R4) receive led active low, lit by default
// (R5) received packet turns receive led off 90ms
// (R6) link test on and failed: receive led off
// (R7) link up: receive led lit 786ms first
// (R8) collision led active low, unlit by default
// (R9) collision lights led 25ms, retriggerable
// (R10) jabber keeps collision led lit
// (R11) thin select when port field is 10base2
// (R12) transmitter active over 26ms enters jabber
// (R13) collision is transmit and receive both active
// (R14) no valid link pulses means link failed; the code flags it only while link_test_en is high
// (R15) ms counters from clock, reset restores defaults
`timescale 1ns/100ps
`include "esled_consts.vh"

module esled_top (
   input wire clk,
   input wire arst_n,
   input wire tx_active,
   input wire rx_active,
   input wire tx_done,
   input wire rx_done,
   input wire link_pulse_ok,
   input wire link_test_en,
   input wire port_select_hi,
   input wire port_select_lo,
   output reg tx_power_led_n,
   output reg tx_power_led_n_oe_n,
   output reg rx_link_led_n,
   output reg rx_link_led_n_oe_n,
   output reg collision_jabber_led_n,
   output reg collision_jabber_led_n_oe_n,
   output reg thin_select,
   output reg jabber,
   output reg link_failed,
   output reg tx_enable
);

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   reg rst_meta_reg;
   reg rst_n_reg;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   // ----------------------------------------
   // millisecond tick
   // ----------------------------------------
   localparam integer TICK_M1 = `ESLED_TICK_CYC - 1;
   localparam [13:0] TICK_LAST = TICK_M1[13:0];
   reg [13:0] div_reg;
   reg tick_reg;
   always @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         div_reg <= 14'h0000;
         tick_reg <= 1'b0;
      end else if (div_reg == TICK_LAST) begin
         div_reg <= 14'h0000; // [R15]
         tick_reg <= 1'b1;
      end else begin
         div_reg <= div_reg + 14'h0001;
         tick_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // collision and jabber detection
   // ----------------------------------------
   wire collision = tx_active & rx_active; // [R13]
   reg [4:0] jab_ms_reg;
   reg jabber_reg;
   always @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         jab_ms_reg <= 5'h00;
         jabber_reg <= 1'b0;
      end else if (!tx_active) begin
         // jabber clears once the transmitter goes quiet
         jab_ms_reg <= 5'h00;
         jabber_reg <= 1'b0;
      end else if (tick_reg && !jabber_reg) begin
         if (jab_ms_reg == 5'd`ESLED_JABBER_MS) begin
            jabber_reg <= 1'b1; // [R12]
         end else begin
            jab_ms_reg <= jab_ms_reg + 5'h01;
         end
      end
   end

   // ----------------------------------------
   // link monitor
   // ----------------------------------------
   reg link_fail_reg;
   // link test off reads as link good, so turning it off ends a failure
   always @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         link_fail_reg <= 1'b0;
      end else begin
         link_fail_reg <= link_test_en & ~link_pulse_ok; // [R14]
      end
   end

   // ----------------------------------------
   // interval lengths
   // ----------------------------------------
   // all esled_interval timers share one width; the link window is the widest
   function [9:0] ms_len;
      input integer ms;
      begin
         ms_len = ms[9:0];
      end
   endfunction

   localparam [9:0] TX_OFF_LEN = ms_len(`ESLED_TX_OFF_MS);
   localparam [9:0] TX_HOLD_LEN = ms_len(`ESLED_TX_MIN_ON_MS);
   localparam [9:0] RX_OFF_LEN = ms_len(`ESLED_RX_OFF_MS);
   localparam [9:0] LINK_ON_LEN = ms_len(`ESLED_LINK_ON_MS);
   localparam [9:0] COL_ON_LEN = ms_len(`ESLED_COL_ON_MS);

   // ----------------------------------------
   // transmit led sequencer
   // ----------------------------------------
   localparam [2:0] TX_LIT = 3'h1;
   localparam [2:0] TX_DARK = 3'h2;
   localparam [2:0] TX_HOLD = 3'h4;

   wire tx_off_busy;
   wire tx_hold_busy;
   reg [2:0] tx_state_reg;
   reg [2:0] tx_state_next;
   reg tx_off_go;
   reg tx_hold_go;

   // timer and state move on one edge, so no cycle slips between them
   always @* begin
      tx_state_next = tx_state_reg;
      tx_off_go = 1'b0;
      tx_hold_go = 1'b0;
      case (tx_state_reg)
         TX_LIT: begin
            if (tx_done) begin
               tx_state_next = TX_DARK;
               tx_off_go = 1'b1; // [R2]
            end
         end
         TX_DARK: begin
            if (!tx_off_busy) begin
               tx_state_next = TX_HOLD;
               tx_hold_go = 1'b1; // [R3]
            end
         end
         TX_HOLD: begin
            // blinks asked for here are dropped, the lit gap is kept
            if (!tx_hold_busy) begin
               tx_state_next = TX_LIT;
            end
         end
         default: begin
            tx_state_next = TX_LIT;
         end
      endcase
   end

   always @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         tx_state_reg <= TX_LIT; // [R15]
      end else begin
         tx_state_reg <= tx_state_next;
      end
   end

   esled_interval #(.W(10)) u_tx_off (
      .clk(clk),
      .rst_n(rst_n_reg),
      .tick(tick_reg),
      .start(tx_off_go), // [R2]
      .length(TX_OFF_LEN),
      .busy(tx_off_busy)
   );
   esled_interval #(.W(10)) u_tx_hold (
      .clk(clk),
      .rst_n(rst_n_reg),
      .tick(tick_reg),
      .start(tx_hold_go), // [R3]
      .length(TX_HOLD_LEN),
      .busy(tx_hold_busy)
   );

   // ----------------------------------------
   // receive led sequencer
   // ----------------------------------------
   localparam [3:0] RX_LIT = 4'h1;
   localparam [3:0] RX_DARK = 4'h2;
   localparam [3:0] RX_FAIL = 4'h4;
   localparam [3:0] RX_SETTLE = 4'h8;

   wire rx_off_busy;
   wire link_on_busy;
   reg [3:0] rx_state_reg;
   reg [3:0] rx_state_next;
   reg rx_off_go;
   reg link_on_go;

   always @* begin
      rx_state_next = rx_state_reg;
      rx_off_go = 1'b0;
      link_on_go = 1'b0;
      case (rx_state_reg)
         RX_LIT: begin
            if (rx_done) begin
               rx_state_next = RX_DARK;
               rx_off_go = 1'b1; // [R5]
            end
         end
         RX_DARK: begin
            // a new packet restarts the full off time
            if (rx_done) begin
               rx_off_go = 1'b1; // [R5]
            end else if (!rx_off_busy) begin
               rx_state_next = RX_LIT;
            end
         end
         RX_FAIL: begin
            if (!link_fail_reg) begin
               rx_state_next = RX_SETTLE;
               link_on_go = 1'b1; // [R7]
            end
         end
         RX_SETTLE: begin
            // packets in the settle window are dropped, not queued
            if (!link_on_busy) begin
               rx_state_next = RX_LIT;
            end
         end
         default: begin
            rx_state_next = RX_LIT;
         end
      endcase
      // a failing link overrides every state
      if (link_fail_reg) begin
         rx_state_next = RX_FAIL; // [R6]
         rx_off_go = 1'b0;
      end
   end

   always @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         rx_state_reg <= RX_LIT; // [R15]
      end else begin
         rx_state_reg <= rx_state_next;
      end
   end

   esled_interval #(.W(10)) u_rx_off (
      .clk(clk),
      .rst_n(rst_n_reg),
      .tick(tick_reg),
      .start(rx_off_go), // [R5]
      .length(RX_OFF_LEN),
      .busy(rx_off_busy)
   );
   esled_interval #(.W(10)) u_link_on (
      .clk(clk),
      .rst_n(rst_n_reg),
      .tick(tick_reg),
      .start(link_on_go), // [R7]
      .length(LINK_ON_LEN),
      .busy(link_on_busy)
   );

   // ----------------------------------------
   // collision timer
   // ----------------------------------------
   wire col_busy;
   esled_interval #(.W(10)) u_col (
      .clk(clk),
      .rst_n(rst_n_reg),
      .tick(tick_reg),
      .start(collision), // [R9]
      .length(COL_ON_LEN),
      .busy(col_busy)
   );

   // ----------------------------------------
   // led and pin registers
   // ----------------------------------------
   // led pins are open drain: oe_n low pulls the led on, high releases it
   always @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         tx_power_led_n <= 1'b0;
         tx_power_led_n_oe_n <= 1'b0; // [R1] [R15]
         rx_link_led_n <= 1'b0;
         rx_link_led_n_oe_n <= 1'b0; // [R4]
         collision_jabber_led_n <= 1'b0;
         collision_jabber_led_n_oe_n <= 1'b1; // [R8]
         thin_select <= 1'b0;
         jabber <= 1'b0;
         link_failed <= 1'b0;
         tx_enable <= 1'b1;
      end else begin
         tx_power_led_n <= 1'b0;
         tx_power_led_n_oe_n <= (tx_state_reg == TX_DARK); // [R1] [R2]
         rx_link_led_n <= 1'b0;
         // a failed link darkens at once, the settle state keeps it lit
         rx_link_led_n_oe_n <= link_fail_reg |
            (rx_state_reg == RX_DARK); // [R6] [R7] [R5]
         collision_jabber_led_n <= 1'b0;
         collision_jabber_led_n_oe_n <=
            ~(col_busy | jabber_reg); // [R9] [R10]
         thin_select <= ({port_select_hi, port_select_lo} ==
            `ESLED_PORT_10BASE2); // [R11]
         jabber <= jabber_reg;
         link_failed <= link_fail_reg;
         tx_enable <= ~jabber_reg & ~link_fail_reg; // [R12] [R14]
      end
   end

endmodule // esled_top

// ==== pkg/esled_consts.vh ====
// esled_consts.vh: timing counts and encodings for the status led driver
// assumes a 10 MHz clock (100 ns period)
`ifndef ESLED_CONSTS_VH
`define ESLED_CONSTS_VH

// ----------------------------------------
// clock and tick
// ----------------------------------------
`define ESLED_CLK_HZ 10000000
`define ESLED_TICK_US 1000
// cycles per 1 ms tick
`define ESLED_TICK_CYC ((`ESLED_CLK_HZ / 1000000) * `ESLED_TICK_US)

// ----------------------------------------
// led and jabber intervals, in ms ticks
// ----------------------------------------
`define ESLED_TX_OFF_MS 90
`define ESLED_TX_MIN_ON_MS 18
`define ESLED_RX_OFF_MS 90
`define ESLED_LINK_ON_MS 786
`define ESLED_COL_ON_MS 25
`define ESLED_JABBER_MS 26

// ----------------------------------------
// port select encodings
// ----------------------------------------
`define ESLED_PORT_10BASE2 2'b10

`endif

// ==== verification/esled_led_model.sv ====
// esled_led_model.sv: leds on open-drain lines
// assumes a pull-up on every led line
`timescale 1ns/100ps
module esled_led_model (
   input logic tx_power_led_n,
   input logic tx_power_led_n_oe_n,
   input logic rx_link_led_n,
   input logic rx_link_led_n_oe_n,
   input logic collision_jabber_led_n,
   input logic collision_jabber_led_n_oe_n,
   output logic tx_lit,
   output logic rx_lit,
   output logic col_lit
);
   // a released line floats to the pull-up, so its led stays dark;
   // a driven line shows the pin value, so a wrong level is seen too
   assign tx_lit = !(tx_power_led_n_oe_n ? 1'b1 : tx_power_led_n);
   assign rx_lit = !(rx_link_led_n_oe_n ? 1'b1 : rx_link_led_n);
   assign col_lit = !(collision_jabber_led_n_oe_n ? 1'b1 :
      collision_jabber_led_n);
endmodule // esled_led_model

// ==== verification/esled_top_assertions.sv ====
// esled_top_assertions.sv: port checks of the led driver
// assumes binding to esled_top
`timescale 1ns/100ps
module esled_top_checker (
   input logic clk,
   input logic arst_n,
   input logic tx_active,
   input logic rx_active,
   input logic tx_done,
   input logic link_pulse_ok,
   input logic link_test_en,
   input logic port_select_hi,
   input logic port_select_lo,
   input logic jabber,
   input logic tx_power_led_n_oe_n,
   input logic rx_link_led_n_oe_n,
   input logic thin_select,
   input logic collision_jabber_led_n_oe_n,
   input logic link_failed,
   input logic tx_enable
);
   // the design's own reset copy lets go two edges late; wait one more
   logic [2:0] live_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         live_q <= 3'h0;
      end else begin
         live_q <= {live_q[1:0], 1'b1};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!live_q[2]);
   sequence s_coll; tx_active && rx_active; endsequence
   a_thin_mode: assert property (port_select_hi && !port_select_lo
      |=> thin_select) else $error("thin");
   a_thin_other: assert property (!port_select_hi || port_select_lo
      |=> !thin_select) else $error("thin off");
   a_tx_cause: assert property ($rose(tx_power_led_n_oe_n) |->
      $past(tx_done, 2)) else $error("tx");
   a_col_detect: assert property (s_coll |-> ##2
      !collision_jabber_led_n_oe_n) else $error("col");
   a_link_fail: assert property (link_test_en && !link_pulse_ok
      |-> ##2 link_failed) else $error("link");
   a_rx_dark: assert property (link_failed |-> ##[0:2]
      rx_link_led_n_oe_n) else $error("rx");
   a_txen_off: assert property (jabber || link_failed |-> ##[0:2]
      !tx_enable) else $error("txen");
   a_jab_clear: assert property (!tx_active |-> ##2 !jabber)
      else $error("jab");
endmodule // esled_top_checker
bind esled_top esled_top_checker chk_i (.*);

// ==== verification/ethernet_status_led_driver_bench.sv ====
// ethernet_status_led_driver_bench.sv: directed led driver tests
// assumes model and checker compiled first
`timescale 1ns/100ps
module ethernet_status_led_driver_bench;
   logic clk = 0, arst_n = 0, tx_active = 0, rx_active = 0, tx_done = 0;
   logic rx_done = 0, link_pulse_ok = 1, link_test_en = 1;
   logic port_select_hi = 0, port_select_lo = 0;
   wire tx_power_led_n, tx_power_led_n_oe_n, rx_link_led_n, jabber;
   wire rx_link_led_n_oe_n, collision_jabber_led_n, thin_select, tx_enable;
   wire collision_jabber_led_n_oe_n, link_failed, tx_lit, rx_lit, col_lit;
   int err_total = 0, samples_checked = 0;
   always #50 clk = ~clk;
   esled_top DUT (.*);
   esled_led_model leds (.*);
   task cyc(input int n); repeat (n) @(negedge clk); endtask
   task chk(input string s, input logic v, input logic e);
      samples_checked++;
      err_total += (v !== e);
      if (v !== e)
         $display("CHECK FAILED %s expected %b seen %b", s, e, v);
   endtask
   task summarize;
      if (err_total == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task t_reset;
      arst_n = 0;
      // at start-up the reset copy only clears on the first rising edge
      cyc(2);
      chk("tx", tx_lit, 1);
      chk("rx", rx_lit, 1);
      chk("col", col_lit, 0);
      chk("jabber", jabber, 0);
      chk("txen", tx_enable, 1);
      cyc(18);
      arst_n = 1;
      cyc(3);
   endtask
   task t_thin;
      for (int i = 0; i < 4; i++) begin
         {port_select_hi, port_select_lo} = i[1:0];
         cyc(2);
         chk("thin", thin_select, i == 2);
      end
   endtask
   task t_col_link;
      {tx_active, rx_active} = 2'h3;
      cyc(1);
      {tx_active, rx_active} = 2'h0;
      cyc(2);
      chk("col", col_lit, 1);
      link_pulse_ok = 0;
      cyc(4);
      chk("rx fail", rx_lit, 0);
      chk("link failed", link_failed, 1);
      chk("txen fail", tx_enable, 0);
      link_pulse_ok = 1;
      cyc(4);
      chk("rx up", rx_lit, 1);
      chk("txen up", tx_enable, 1);
      // a packet inside the settle window must not blink the led
      rx_done = 1;
      cyc(1);
      rx_done = 0;
      cyc(3);
      chk("rx settle", rx_lit, 1);
   endtask
   // 3 ms in, well short of the 90 ms off time
   task t_blink;
      {tx_done, rx_done} = 2'h3;
      cyc(1);
      {tx_done, rx_done} = 2'h0;
      cyc(30000);
      chk("tx", tx_lit, 0);
      chk("rx", rx_lit, 0);
   endtask
   initial begin
      t_reset;
      t_thin;
      t_col_link;
      t_reset;
      t_blink;
      summarize;
   end
   initial begin
      cyc(60000);
      err_total++;
      summarize;
   end
endmodule // ethernet_status_led_driver_bench
